/* File: core/deep_sync_fifo.sv */
// Purpose: Deep nine-bit FIFO with pin write/read ports, flags and APB access.
// Assumes: Port clocks arrive as pins, run well below clk/6 and are oversampled.
// Notes:   Flag offsets are loadable through the pins or over APB.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defs.svh"

module deep_sync_fifo #(
    parameter int DEPTH = 65536
) (
    // Clock and synchronous active-low reset, which is the device reset.
    input wire logic clk,
    input wire logic nrst,
    // Write port pins.
    input wire logic write_clk,
    input wire logic [8:0] write_data,
    input wire logic write_gate_primary_n,
    input wire logic write_gate_or_offset_load,
    // Read port pins.
    input wire logic read_clk,
    input wire logic read_gate_a_n,
    input wire logic read_gate_b_n,
    input wire logic read_drive_n,
    output logic [8:0] read_data,
    output logic read_data_oe,
    // Status flags, all active low.
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // ****************************************
    // Pin synchronisation and edge detection
    // ****************************************
    logic [`FIFO_PIN_COUNT-1:0] pin_level;
    logic wclk_prev;
    logic rclk_prev;
    logic wr_edge;
    logic rd_edge;
    logic load_level;

    pin_sync #(.WIDTH(`FIFO_PIN_COUNT)) u_pin_sync (
        .clk(clk),
        .pins({read_drive_n, read_clk, read_gate_b_n, read_gate_a_n, write_clk,
               write_gate_or_offset_load, write_gate_primary_n, write_data}),
        .level(pin_level)
    );

    // Previous clock levels follow freely; edges are ignored while reset is held.
    always_ff @(posedge clk) begin
        wclk_prev <= pin_level[`FIFO_PIN_WCLK];
        rclk_prev <= pin_level[`FIFO_PIN_RCLK];
    end

    // Both port clocks are oversampled the same way, so related or unrelated
    // clocks behave identically.
    assign wr_edge = nrst && pin_level[`FIFO_PIN_WCLK] && !wclk_prev;
    assign rd_edge = nrst && pin_level[`FIFO_PIN_RCLK] && !rclk_prev;
    assign load_level = pin_level[`FIFO_PIN_WGATE2_LD];

    // ****************************************
    // Configuration strap
    // ****************************************
    fifo_pkg::config_mode_t config_mode;

    // The dual-role pin is caught on every clock while reset is held.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            config_mode <= load_level ? fifo_pkg::mode_dual_enable
                                      : fifo_pkg::mode_offset_load;
        end
    end

    // ****************************************
    // Write and read qualification
    // ****************************************
    logic load_mode;
    logic load_active;
    logic data_write;
    logic data_read;
    logic offset_write;
    logic offset_read;
    logic both_read_gates;

    assign load_mode = (config_mode == fifo_pkg::mode_offset_load);
    assign load_active = load_mode && !load_level;
    // Gate one and gate two (dual pin high) are both needed in either mode; never when full.
    assign data_write = wr_edge && !pin_level[`FIFO_PIN_WGATE1_N] && load_level
                        && full_flag_n;
    // Both read gates must be low; any one high blocks the read.
    assign both_read_gates = !pin_level[`FIFO_PIN_RGATE_A_N]
                             && !pin_level[`FIFO_PIN_RGATE_B_N];
    assign data_read = rd_edge && both_read_gates && empty_flag_n && !load_active;
    assign offset_write = wr_edge && load_active;
    assign offset_read = rd_edge && load_active;

    // ****************************************
    // Storage and pointers
    // ****************************************
    logic [8:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] rd_ptr_inc;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    assign rd_ptr_inc = rd_ptr + 1'b1;

    // Memory holds no reset; the pointers define what is valid.
    always_ff @(posedge clk) begin
        if (data_write) begin
            mem[wr_ptr] <= pin_level[`FIFO_PIN_DATA_MSB:`FIFO_PIN_DATA_LSB];
        end
    end

    // Write pointer steps once per accepted write-clock rise.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
        end else if (data_write) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Read pointer steps only on a real read, never on an empty read.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_ptr <= '0;
        end else if (data_read) begin
            rd_ptr <= rd_ptr_inc;
        end
    end

    // Fill level tolerates a write and a read in the same cycle.
    always_comb begin
        next_count = count;
        if (data_write && !data_read) begin
            next_count = count + 1'b1;
        end else if (data_read && !data_write) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // ****************************************
    // Flag offset register
    // ****************************************
    logic [CW-1:0] ae_offset;
    logic [CW-1:0] af_offset;
    fifo_pkg::offset_sel_t wr_sel;
    fifo_pkg::offset_sel_t rd_sel;
    logic apb_write;

    assign apb_write = psel && penable && pwrite;

    // Pin loads step through the two parts in order; they beat APB writes.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ae_offset <= CW'(`FIFO_AE_OFFSET_RST);
            af_offset <= CW'(`FIFO_AF_OFFSET_RST);
            wr_sel <= fifo_pkg::sel_almost_empty;
        end else if (offset_write) begin
            case (wr_sel)
                fifo_pkg::sel_almost_empty: begin
                    ae_offset <= CW'(pin_level[`FIFO_PIN_DATA_MSB:`FIFO_PIN_DATA_LSB]);
                    wr_sel <= fifo_pkg::sel_almost_full;
                end
                fifo_pkg::sel_almost_full: begin
                    af_offset <= CW'(pin_level[`FIFO_PIN_DATA_MSB:`FIFO_PIN_DATA_LSB]);
                    wr_sel <= fifo_pkg::sel_almost_empty;
                end
                default: begin
                    wr_sel <= fifo_pkg::sel_almost_empty;
                end
            endcase
        end else if (apb_write && paddr == `FIFO_REG_AE_OFFSET) begin
            ae_offset <= pwdata[CW-1:0];
        end else if (apb_write && paddr == `FIFO_REG_AF_OFFSET) begin
            af_offset <= pwdata[CW-1:0];
        end
    end

    // Read-side walk through the parts runs independently of the write side.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_sel <= fifo_pkg::sel_almost_empty;
        end else if (offset_read) begin
            rd_sel <= (rd_sel == fifo_pkg::sel_almost_empty) ? fifo_pkg::sel_almost_full
                                                             : fifo_pkg::sel_almost_empty;
        end
    end

    // ****************************************
    // Output word and drive
    // ****************************************
    logic [8:0] offset_word;

    // Size casts keep a shallow build legal, where the offsets are under nine bits wide.
    assign offset_word = (rd_sel == fifo_pkg::sel_almost_full) ? 9'(af_offset)
                                                               : 9'(ae_offset);

    // Outputs go low at reset; an empty read holds the last word.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            read_data <= '0;
        end else if (offset_read) begin
            read_data <= offset_word;
        end else if (data_read) begin
            read_data <= mem[rd_ptr];
        end
    end

    // The pad drives only while the synchronised enable is low.
    assign read_data_oe = nrst && !pin_level[`FIFO_PIN_DRIVE_N];

    // ****************************************
    // Status flags
    // ****************************************
    // One clock domain here, so the level is coherent; every flag follows the next
    // level, so full side and empty side flags move on write and read events alike.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
            full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end else begin
            empty_flag_n <= (next_count != '0);
            full_flag_n <= (next_count != DEPTH_C);
            almost_empty_flag_n <= (next_count > ae_offset);
            almost_full_flag_n <= (next_count < DEPTH_C - af_offset);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    logic [31:0] next_prdata;
    logic next_slverr;

    // Zero wait states: the answer is registered in the setup cycle.
    assign pready = 1'b1;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (paddr)
            `FIFO_REG_STATUS: begin
                next_prdata[`FIFO_ST_EMPTY_N] = empty_flag_n;
                next_prdata[`FIFO_ST_FULL_N] = full_flag_n;
                next_prdata[`FIFO_ST_AE_N] = almost_empty_flag_n;
                next_prdata[`FIFO_ST_AF_N] = almost_full_flag_n;
                next_prdata[`FIFO_ST_LOAD_MODE] = load_mode;
            end
            `FIFO_REG_LEVEL: next_prdata[CW-1:0] = count;
            `FIFO_REG_AE_OFFSET: next_prdata[CW-1:0] = ae_offset;
            `FIFO_REG_AF_OFFSET: next_prdata[CW-1:0] = af_offset;
            default: next_slverr = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_slverr;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    no_write_full_a: assert property (
        (wr_edge && !full_flag_n) |=> $stable(wr_ptr))
        else $error("write pointer moved while full");

    write_count_a: assert property (
        (data_write && !data_read) |=> count == $past(count) + 1'b1)
        else $error("accepted write did not raise the level");

    read_empty_a: assert property (
        (rd_edge && !empty_flag_n && !load_active) |=> $stable(read_data) && $stable(rd_ptr))
        else $error("empty read changed output or pointer");

    read_advance_a: assert property (
        data_read |=> rd_ptr == $past(rd_ptr_inc) && read_data == $past(mem[rd_ptr]))
        else $error("read did not present oldest word and advance");

    empty_flag_a: assert property (
        (count == '0) |-> !empty_flag_n && almost_empty_flag_n == 1'b0)
        else $error("empty flag not low at zero level");

    full_flag_a: assert property (
        (count == DEPTH_C) |-> !full_flag_n ##1 (count != DEPTH_C || !full_flag_n))
        else $error("full flag not low at full level");

    offset_default_a: assert property (
        $rose(nrst) |-> ae_offset == CW'(7) && af_offset == CW'(7))
        else $error("offsets not seven after reset");

    mode_strap_a: assert property (
        $rose(nrst) |-> load_mode == !$past(load_level))
        else $error("strap not captured during reset");

    offset_out_a: assert property (
        offset_read |=> read_data == $past(offset_word) && $stable(rd_ptr))
        else $error("load read did not show the offset");

    offset_load_a: assert property (
        offset_write |=> $stable(wr_ptr) && $stable(count) || $past(data_read))
        else $error("load write touched the data memory");

endmodule : deep_sync_fifo

`default_nettype wire

/* File: core/fifo_defs.svh */
// Purpose: Offsets, field positions and reset values of the deep nine-bit FIFO.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only; no logic lives here.
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

// ****************************************
// APB register byte offsets
// ****************************************
`define FIFO_REG_STATUS 12'h000
`define FIFO_REG_LEVEL 12'h004
`define FIFO_REG_AE_OFFSET 12'h008
`define FIFO_REG_AF_OFFSET 12'h00C

// ****************************************
// Status register bit positions
// ****************************************
`define FIFO_ST_EMPTY_N 0
`define FIFO_ST_FULL_N 1
`define FIFO_ST_AE_N 2
`define FIFO_ST_AF_N 3
`define FIFO_ST_LOAD_MODE 4

// ****************************************
// Positions inside the synchronised pin vector
// ****************************************
`define FIFO_PIN_DATA_LSB 0
`define FIFO_PIN_DATA_MSB 8
`define FIFO_PIN_WGATE1_N 9
`define FIFO_PIN_WGATE2_LD 10
`define FIFO_PIN_WCLK 11
`define FIFO_PIN_RGATE_A_N 12
`define FIFO_PIN_RGATE_B_N 13
`define FIFO_PIN_RCLK 14
`define FIFO_PIN_DRIVE_N 15
`define FIFO_PIN_COUNT 16

// ****************************************
// Reset values
// ****************************************
`define FIFO_AE_OFFSET_RST 7
`define FIFO_AF_OFFSET_RST 7

`endif

/* File: core/fifo_pkg.sv */
// Purpose: Types shared by the deep nine-bit FIFO.
// Assumes: Nothing is imported; users write fifo_pkg::name.
// Notes:   Numbers live in fifo_defs.svh.
package fifo_pkg;

    // Role of the dual-role write gate, caught while reset is held and fixed after.
    typedef enum logic {mode_dual_enable, mode_offset_load} config_mode_t;

    // Which flag offset the next load access touches.
    typedef enum logic {sel_almost_empty, sel_almost_full} offset_sel_t;

endpackage : fifo_pkg

/* File: core/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for a group of pins.
// Assumes: Pins change no faster than once every few clk cycles.
// Notes:   Stages carry no reset so a strap level is visible while reset is held.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 16
) (
    // Clock.
    input wire logic clk,
    // Raw pins and their filtered copy.
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] level
);

    // ****************************************
    // Per-bit synchroniser
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // The first stage feeds only the second, keeping metastability contained.
            always_ff @(posedge clk) begin
                s1 <= pins[i];
                s2 <= s1;
                s3 <= s2;
            end
            // A change counts only once the second and third stages agree.
            always_ff @(posedge clk) begin
                if (s2 == s3) begin
                    level[i] <= s3;
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

/* File: verification/fifo_port_model.sv */
// Purpose: Writer and reader logic that drives the FIFO's pin ports.
// Assumes: Port clocks stand still outside transfers and step in clk units.
// Notes:   Each phase is four clk cycles, so a port period is twelve cycles.
`timescale 1ns/1ps
`default_nettype none

module fifo_port_model (
    // Clock.
    input wire logic clk,
    // Write port.
    output logic write_clk,
    output logic [8:0] write_data,
    output logic write_gate_primary_n,
    output logic write_gate_or_offset_load,
    // Read port.
    output logic read_clk,
    output logic read_gate_a_n,
    output logic read_gate_b_n
);
    // ****************************************
    // Pin sequencing
    // ****************************************
    // Idle levels keep both ports closed until a task opens them.
    initial begin
        write_clk = 1'b0;
        write_data = 9'h000;
        write_gate_primary_n = 1'b1;
        write_gate_or_offset_load = 1'b1;
        read_clk = 1'b0;
        read_gate_a_n = 1'b1;
        read_gate_b_n = 1'b1;
    end

    // Slow clock pulse; the block oversamples, so each level needs four cycles.
    task automatic pulse(input bit wr);
        repeat (4) @(posedge clk);
        if (wr) write_clk <= 1'b1; else read_clk <= 1'b1;
        repeat (4) @(posedge clk);
        if (wr) write_clk <= 1'b0; else read_clk <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    // Strap level of the dual-role pin, set ahead of a reset.
    task automatic set_dual(input logic v);
        @(posedge clk);
        write_gate_or_offset_load <= v;
    endtask : set_dual

    // One write clock with the given gates; dual pin low means offset load when strapped for load, a closed gate otherwise.
    task automatic write_word(input logic [8:0] d, input logic g1_n, input logic g2);
        @(posedge clk);
        write_data <= d;
        write_gate_primary_n <= g1_n;
        write_gate_or_offset_load <= g2;
        pulse(1'b1);
        write_gate_primary_n <= 1'b1;
        // A released data bus shows the inverted word, never the last word.
        write_data <= ~d;
    endtask : write_word

    // One read clock; both gates are needed for a read to count.
    task automatic read_word(input logic a_n, input logic b_n);
        @(posedge clk);
        read_gate_a_n <= a_n;
        read_gate_b_n <= b_n;
        pulse(1'b0);
        read_gate_a_n <= 1'b1;
        read_gate_b_n <= 1'b1;
    endtask : read_word
endmodule : fifo_port_model

`default_nettype wire

/* File: verification/deep_sync_fifo_tb.sv */
// Purpose: Self-checking bench for the deep nine-bit FIFO.
// Assumes: The port model drives the pins; APB tasks reach the registers.
// Notes:   Depth is cut to 16 so the full condition is reached quickly.
`timescale 1ns/1ps
`default_nettype none

module deep_sync_fifo_9bit_tb;
    localparam int depth = 16;
    logic clk, nrst, read_drive_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [8:0] read_data, v;
    logic read_data_oe, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
    wire logic write_clk, write_gate_primary_n, write_gate_or_offset_load;
    wire logic read_clk, read_gate_a_n, read_gate_b_n;
    wire logic [8:0] write_data;
    int fails, comparisons;

    // ****************************************
    // Instances and clock
    // ****************************************
    deep_sync_fifo #(.DEPTH(depth)) i_dut (.clk(clk), .nrst(nrst), .write_clk(write_clk),
        .write_data(write_data), .write_gate_primary_n(write_gate_primary_n),
        .write_gate_or_offset_load(write_gate_or_offset_load), .read_clk(read_clk),
        .read_gate_a_n(read_gate_a_n), .read_gate_b_n(read_gate_b_n),
        .read_drive_n(read_drive_n), .read_data(read_data), .read_data_oe(read_data_oe),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fifo_port_model i_host (.clk(clk), .write_clk(write_clk), .write_data(write_data),
        .write_gate_primary_n(write_gate_primary_n),
        .write_gate_or_offset_load(write_gate_or_offset_load), .read_clk(read_clk),
        .read_gate_a_n(read_gate_a_n), .read_gate_b_n(read_gate_b_n));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // APB transfer; the request is held until pready is seen high, and only the
    // watchdog ends a wait that never finishes.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic reg_rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, q, exp);
    endtask : reg_rd

    // Flags are packed empty, full, almost empty, almost full, all active low.
    task automatic flags(input logic [3:0] exp);
        @(negedge clk);
        check("flags", {28'h0, empty_flag_n, full_flag_n, almost_empty_flag_n,
            almost_full_flag_n}, {28'h0, exp});
    endtask : flags

    task automatic rd_exp(input logic [8:0] exp);
        i_host.read_word(1'b0, 1'b0);
        @(negedge clk);
        check("read_data", {23'h0, read_data}, {23'h0, exp});
    endtask : rd_exp

    // The strap must be stable through several synchroniser stages.
    task automatic do_reset(input logic strap);
        i_host.set_dual(strap);
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Watchdog sized well above the roughly 800 cycles the tests take.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin : main
        fails = 0;
        comparisons = 0;
        nrst = 1'b0;
        read_drive_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        do_reset(1'b1);
        flags(4'b0101);
        check("read_data", {23'h0, read_data}, 32'h0);
        reg_rd("status", 12'h000, 32'h0000000A);
        reg_rd("ae_offset", 12'h008, 32'h7);
        reg_rd("af_offset", 12'h00C, 32'h7);
        reg_rd("unmapped", 12'h010, 32'h0);
        check("pslverr", {31'h0, err}, 32'h1);
        check("pready", {31'h0, pready}, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        reg_rd("status", 12'h000, 32'h0000000A);
        // A depth of 16 gives offsets five bits wide, so only those bits stick.
        apb(1'b1, 12'h00C, 32'hFFFFFFFF);
        reg_rd("af_offset", 12'h00C, 32'h0000001F);
        apb(1'b1, 12'h00C, 32'h7);
        // Threshold three leaves every later flag expectation as it is at seven.
        apb(1'b1, 12'h008, 32'h3);
        reg_rd("ae_offset", 12'h008, 32'h3);
        read_drive_n <= 1'b0;
        repeat (8) @(negedge clk);
        check("oe", {31'h0, read_data_oe}, 32'h1);
        $display("test reset done");
        // Gated writes and reads; single gates must be refused.
        i_host.write_word(9'h1A5, 1'b0, 1'b1);
        i_host.write_word(9'h05A, 1'b0, 1'b1);
        i_host.write_word(9'h100, 1'b0, 1'b1);
        i_host.write_word(9'h0FF, 1'b1, 1'b1);
        i_host.write_word(9'h0FF, 1'b0, 1'b0);
        reg_rd("level", 12'h004, 32'h3);
        flags(4'b1101);
        i_host.read_word(1'b0, 1'b1);
        i_host.read_word(1'b1, 1'b0);
        reg_rd("level", 12'h004, 32'h3);
        rd_exp(9'h1A5);
        rd_exp(9'h05A);
        rd_exp(9'h100);
        flags(4'b0101);
        rd_exp(9'h100);
        reg_rd("level", 12'h004, 32'h0);
        $display("test gates done");
        // Fill to the top, overflow, then drain with a crossing write and read.
        for (int i = 0; i < depth; i++) begin
            v = 9'h0F0 + 9'(i);
            i_host.write_word(v, 1'b0, 1'b1);
        end
        flags(4'b1010);
        i_host.write_word(9'h0AA, 1'b0, 1'b1);
        reg_rd("level", 12'h004, 32'h10);
        for (int i = 0; i < 8; i++) begin
            rd_exp(9'h0F0 + 9'(i));
        end
        fork
            i_host.write_word(9'h033, 1'b0, 1'b1);
            rd_exp(9'h0F8);
        join
        reg_rd("level", 12'h004, 32'h8);
        for (int i = 9; i < depth; i++) begin
            rd_exp(9'h0F0 + 9'(i));
        end
        rd_exp(9'h033);
        flags(4'b0101);
        $display("test fill done");
        // Load configuration strapped at reset.
        do_reset(1'b0);
        reg_rd("status", 12'h000, 32'h0000001A);
        reg_rd("level", 12'h004, 32'h0);
        i_host.write_word(9'h005, 1'b1, 1'b0);
        i_host.write_word(9'h009, 1'b1, 1'b0);
        reg_rd("ae_offset", 12'h008, 32'h5);
        reg_rd("af_offset", 12'h00C, 32'h9);
        reg_rd("level", 12'h004, 32'h0);
        rd_exp(9'h005);
        rd_exp(9'h009);
        rd_exp(9'h005);
        i_host.write_word(9'h1C3, 1'b0, 1'b1);
        i_host.write_word(9'h1C4, 1'b1, 1'b1);
        reg_rd("level", 12'h004, 32'h1);
        rd_exp(9'h1C3);
        read_drive_n <= 1'b1;
        repeat (8) @(negedge clk);
        check("oe", {31'h0, read_data_oe}, 32'h0);
        $display("test load done");
        results();
    end
endmodule : deep_sync_fifo_9bit_tb

`default_nettype wire
